// >>> logic/acs_map.vh
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// register addresses (12-bit serial address space)
`define ACS_ADDR_FE_CTRL 12'h000
`define ACS_ADDR_OUT_FMT 12'h001
`define ACS_ADDR_CLAMP_LEVEL 12'h003
`define ACS_ADDR_CDS_GAIN 12'h004
`define ACS_ADDR_VGA_GAIN 12'h005
`define ACS_ADDR_CLK_HALVE 12'h00D
`define ACS_ADDR_SOFT_RST 12'h010
`define ACS_ADDR_OUT_EN 12'h011
`define ACS_ADDR_SYNC_CTRL 12'h013
`define ACS_ADDR_CORE_RUN 12'h014
`define ACS_ADDR_OSC_EN 12'h015
`define ACS_ADDR_VERT_ROLE 12'h01C
`define ACS_ADDR_MASTER 12'h020
`define ACS_ADDR_VERT_POL 12'h026
`define ACS_ADDR_SAMPLE_LOC 12'h037
`define ACS_ADDR_OUT_PHASE 12'h038
`define ACS_ADDR_STATUS 12'h03F
`define ACS_ADDR_STARTUP 12'h0D8

// reset values
`define ACS_RST_FE_CTRL 12'h003
`define ACS_RST_OUT_FMT 12'h000
`define ACS_RST_CLAMP_LEVEL 10'h000
`define ACS_RST_CDS_GAIN 12'h000
`define ACS_RST_VGA_GAIN 10'h000
`define ACS_RST_SYNC_CTRL 16'h0000
`define ACS_RST_VERT 24'h00_0000
`define ACS_RST_SAMPLE_LOC 12'h800
`define ACS_RST_OUT_PHASE 8'h00
`define ACS_RST_STARTUP 12'h000

// field positions
`define ACS_FE_POWER 1:0
`define ACS_FE_CLAMP_EN 2
`define ACS_FE_RATE 5:4
`define ACS_FE_DC_IN_PREBLANK_PULSE 6
`define ACS_FMT_TRISTATE 0
`define ACS_FMT_TRANSPARENT 1
`define ACS_FMT_GRAY 2
`define ACS_SYNC_SW 14
`define ACS_LOC_REF 5:0
`define ACS_LOC_DATA 11:6
`define ACS_PH_POS 5:0
`define ACS_PH_FIXED 6
`define ACS_PH_INV 7
`define ACS_SOFT_RST_BIT 0

`define ACS_POWER_FULL 2'h0
`define ACS_POWER_DEEP 2'h3

// serial frame layout
`define ACS_SER_ADDR_LAST 6'h0C
`define ACS_SER_FRAME_BITS 6'h25

// sync low time
`define ACS_SYNC_LOW_NS 100
`define ACS_CLK_PERIOD_NS 50

`endif

// >>> logic/acs_serial_port.v
`timescale 1ns/10ps
`include "acs_map.vh"

// 3-wire port: frame of rw bit, 12 address bits, 24 data bits, msb first
module acs_serial_port (
    input wire clk,
    input wire rst,
    input wire serialClk,
    input wire serialDataIn,
    input wire serialLoadN,
    input wire [23:0] rdData,
    output wire [11:0] regAddr,
    output wire [23:0] wrData,
    output reg wrStrobe,
    output reg serialDataOut,
    output reg serialDataOe
);
    reg [1:0] sckSync_r;
    reg [1:0] sdSync_r;
    reg [1:0] ldSync_r;
    reg sckLast_r;
    reg ldLast_r;
    reg isRead_r;
    reg loadRd_r;
    reg [5:0] bitCnt_r;
    reg [11:0] addr_r;
    reg [23:0] data_r;
    reg [23:0] rdShift_r;
    wire sckRise = sckSync_r[1] & ~sckLast_r;
    wire sckFall = ~sckSync_r[1] & sckLast_r;
    wire frameEnd = ldSync_r[1] & ~ldLast_r;
    wire inFrame = ~ldSync_r[1];

    assign regAddr = addr_r;
    assign wrData = data_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sckSync_r <= 2'b00;
            sdSync_r <= 2'b00;
            ldSync_r <= 2'b11;
            sckLast_r <= 1'b0;
            ldLast_r <= 1'b1;
            isRead_r <= 1'b0;
            loadRd_r <= 1'b0;
            bitCnt_r <= 6'h00;
            addr_r <= 12'h000;
            data_r <= 24'h00_0000;
            rdShift_r <= 24'h00_0000;
            wrStrobe <= 1'b0;
            serialDataOut <= 1'b0;
            serialDataOe <= 1'b0;
        end else begin
            sckSync_r <= {sckSync_r[0], serialClk};
            sdSync_r <= {sdSync_r[0], serialDataIn};
            ldSync_r <= {ldSync_r[0], serialLoadN};
            sckLast_r <= sckSync_r[1];
            ldLast_r <= ldSync_r[1];
            wrStrobe <= 1'b0;
            loadRd_r <= 1'b0;
            if (loadRd_r) begin
                rdShift_r <= rdData;
            end
            if (!inFrame) begin
                bitCnt_r <= 6'h00;
                serialDataOe <= 1'b0;
            end
            if (frameEnd) begin
                wrStrobe <= ~isRead_r && (bitCnt_r == `ACS_SER_FRAME_BITS);
            end else if (inFrame && sckRise && bitCnt_r != `ACS_SER_FRAME_BITS) begin
                bitCnt_r <= bitCnt_r + 6'h01;
                if (bitCnt_r == 6'h00) begin
                    isRead_r <= sdSync_r[1];
                end else if (bitCnt_r <= `ACS_SER_ADDR_LAST) begin
                    addr_r <= {addr_r[10:0], sdSync_r[1]};
                    loadRd_r <= (bitCnt_r == `ACS_SER_ADDR_LAST);
                end else begin
                    data_r <= {data_r[22:0], sdSync_r[1]};
                end
            end else if (inFrame && sckFall && isRead_r && bitCnt_r > `ACS_SER_ADDR_LAST) begin
                serialDataOe <= 1'b1;
                serialDataOut <= rdShift_r[23];
                rdShift_r <= {rdShift_r[22:0], 1'b0};
            end
        end
    end
endmodule // acs_serial_port

// >>> logic/acs_top.v
`timescale 1ns/10ps
`include "acs_map.vh"

// Functional notes
// - dc-restore switch closes only in reference sample
// - bit 6 keeps dc-restore during preblank
// - preblank low shorts sampler input to ground
// - sample edges placed from sample_edge_location fields
// - sampler gain minus3, 0 default, plus3
// - 10-bit amplifier gain code, linear dB
// - clamp loop compares target during shielded pixels
// - clamp enable bit; disabled uses fixed offset
// - latch at output phase, or transparent
// - tristate bit floats data outputs
// - output clock tracks phase, fixed, inverted
// - gray coding when format bit set
// - soft reset write restores all defaults
// - vertical outputs reset low, polarity, role
// - timing core held until run bit set
// - master select; enable applies at sync and at each field start
// - sync low 100 ns then high restarts
// - software sync bit makes internal sync
// - power field zero full, three deepest
module acs_top #(
    parameter EDGES_PER_PIXEL = 64,
    parameter PIXELS_PER_LINE = 32,
    parameter LINES_PER_FIELD = 8
) (
    input wire clk,
    input wire rst,
    input wire serialClk,
    input wire serialDataIn,
    input wire serialLoadN,
    input wire preblankN,
    input wire blackClampPulse,
    input wire syncN,
    input wire [11:0] adcData,
    output wire serialDataOut,
    output wire serialDataOe,
    output reg dcRestoreSwitch,
    output reg samplerShort,
    output reg referenceSamplePulse,
    output reg dataSamplePulse,
    output reg [1:0] cdsGainCode,
    output reg [9:0] vgaGainCode,
    output reg [9:0] clampCorrection,
    output reg [1:0] powerMode,
    output reg oscillatorEnable,
    output reg [11:0] dataOut,
    output reg dataOutOe,
    output reg outputDataClock,
    output reg [23:0] verticalOut,
    output reg verticalDrive,
    output reg horizontalDrive
);
    localparam integer SYNC_LOW_CYC =
        (`ACS_SYNC_LOW_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS;

    // registers
    reg [11:0] feCtrl_r;
    reg [11:0] outFmt_r;
    reg [9:0] clampLevel_r;
    reg [11:0] cdsGain_r;
    reg [9:0] vgaGain_r;
    reg clkHalve_r;
    reg outEnable_r;
    reg [15:0] syncCtrl_r;
    reg coreRun_r;
    reg oscEn_r;
    reg [23:0] vertRole_r;
    reg masterSel_r;
    reg [23:0] vertPol_r;
    reg [11:0] sampleLoc_r;
    reg [7:0] outPhase_r;
    reg [11:0] startup_r;

    wire [11:0] regAddr;
    wire [23:0] wrData;
    wire wrStrobe;
    reg [23:0] rdData;

    // timing state
    reg [1:0] pbSync_r;
    reg [1:0] clpSync_r;
    reg [1:0] synSync_r;
    reg synLast_r;
    reg [1:0] lowCnt_r;
    reg halfTick_r;
    reg started_r;
    reg outputsActive_r;
    reg [5:0] edgeCnt_r;
    reg [7:0] pixelCnt_r;
    reg [7:0] lineCnt_r;
    reg xferLevel_r;
    reg clpLast_r;
    reg [15:0] errAcc_r;
    reg [9:0] clampLoop_r;
    reg [3:0] rateCnt_r;

    function [11:0] toGray;
        input [11:0] b;
        begin
            toGray = b ^ {1'b0, b[11:1]};
        end
    endfunction

    function isAddr;
        input [11:0] a;
        input [11:0] target;
        begin
            isAddr = wrStrobe && (a == target);
        end
    endfunction

    acs_serial_port serialPort (
        .clk(clk),
        .rst(rst),
        .serialClk(serialClk),
        .serialDataIn(serialDataIn),
        .serialLoadN(serialLoadN),
        .rdData(rdData),
        .regAddr(regAddr),
        .wrData(wrData),
        .wrStrobe(wrStrobe),
        .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe)
    );

    wire softReset = isAddr(regAddr, `ACS_ADDR_SOFT_RST) &&
        wrData[`ACS_SOFT_RST_BIT];
    wire software_sync_trigger = isAddr(regAddr, `ACS_ADDR_SYNC_CTRL) && wrData[`ACS_SYNC_SW];
    wire deepStandby = feCtrl_r[`ACS_FE_POWER] == `ACS_POWER_DEEP;
    wire coreOn = coreRun_r && !deepStandby;
    wire tick = coreOn && (!clkHalve_r || halfTick_r);
    wire hwSync = synSync_r[1] && !synLast_r && (lowCnt_r >= SYNC_LOW_CYC);
    wire syncEvent = masterSel_r && coreOn && (hwSync || software_sync_trigger);
    wire lastEdge = edgeCnt_r == EDGES_PER_PIXEL - 1;
    wire lastPixel = pixelCnt_r == PIXELS_PER_LINE - 1;
    wire lastLine = lineCnt_r == LINES_PER_FIELD - 1;
    wire fieldStart = tick && started_r && lastEdge && lastPixel && lastLine;
    wire preblankActive = !pbSync_r[1];
    wire clampOn = feCtrl_r[`ACS_FE_CLAMP_EN];
    wire refEdge = edgeCnt_r == sampleLoc_r[`ACS_LOC_REF];
    wire dataEdge = edgeCnt_r == sampleLoc_r[`ACS_LOC_DATA];
    wire [5:0] phasePos = outPhase_r[`ACS_PH_POS];
    wire [5:0] phaseOffset = edgeCnt_r - phasePos;
    wire clampDue = rateCnt_r >= ((4'h1 << feCtrl_r[`ACS_FE_RATE]) - 4'h1);
    wire [13:0] adcQuarter = {adcData, 2'b00};
    wire [11:0] codedData = outFmt_r[`ACS_FMT_GRAY] ? toGray(adcData) : adcData;
    wire driveData = outputsActive_r && !outFmt_r[`ACS_FMT_TRISTATE] && !deepStandby;

    always @* begin
        rdData = 24'h00_0000;
        case (regAddr)
            `ACS_ADDR_FE_CTRL: rdData = {12'h000, feCtrl_r};
            `ACS_ADDR_OUT_FMT: rdData = {12'h000, outFmt_r};
            `ACS_ADDR_CLAMP_LEVEL: rdData = {14'h0000, clampLevel_r};
            `ACS_ADDR_CDS_GAIN: rdData = {12'h000, cdsGain_r};
            `ACS_ADDR_VGA_GAIN: rdData = {14'h0000, vgaGain_r};
            `ACS_ADDR_CLK_HALVE: rdData = {23'h00_0000, clkHalve_r};
            `ACS_ADDR_OUT_EN: rdData = {23'h00_0000, outEnable_r};
            `ACS_ADDR_SYNC_CTRL: rdData = {8'h00, syncCtrl_r};
            `ACS_ADDR_CORE_RUN: rdData = {23'h00_0000, coreRun_r};
            `ACS_ADDR_OSC_EN: rdData = {23'h00_0000, oscEn_r};
            `ACS_ADDR_VERT_ROLE: rdData = vertRole_r;
            `ACS_ADDR_MASTER: rdData = {23'h00_0000, masterSel_r};
            `ACS_ADDR_VERT_POL: rdData = vertPol_r;
            `ACS_ADDR_SAMPLE_LOC: rdData = {12'h000, sampleLoc_r};
            `ACS_ADDR_OUT_PHASE: rdData = {16'h0000, outPhase_r};
            `ACS_ADDR_STATUS: rdData = {11'h000, started_r, outputsActive_r, coreOn,
                clampLoop_r};
            `ACS_ADDR_STARTUP: rdData = {12'h000, startup_r};
            default: rdData = 24'h00_0000;
        endcase
    end

    // register file
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            feCtrl_r <= `ACS_RST_FE_CTRL;
            outFmt_r <= `ACS_RST_OUT_FMT;
            clampLevel_r <= `ACS_RST_CLAMP_LEVEL;
            cdsGain_r <= `ACS_RST_CDS_GAIN;
            vgaGain_r <= `ACS_RST_VGA_GAIN;
            clkHalve_r <= 1'b0;
            outEnable_r <= 1'b0;
            syncCtrl_r <= `ACS_RST_SYNC_CTRL;
            coreRun_r <= 1'b0;
            oscEn_r <= 1'b0;
            vertRole_r <= `ACS_RST_VERT;
            masterSel_r <= 1'b0;
            vertPol_r <= `ACS_RST_VERT;
            sampleLoc_r <= `ACS_RST_SAMPLE_LOC;
            outPhase_r <= `ACS_RST_OUT_PHASE;
            startup_r <= `ACS_RST_STARTUP;
        end else if (softReset) begin
            feCtrl_r <= `ACS_RST_FE_CTRL;
            outFmt_r <= `ACS_RST_OUT_FMT;
            clampLevel_r <= `ACS_RST_CLAMP_LEVEL;
            cdsGain_r <= `ACS_RST_CDS_GAIN;
            vgaGain_r <= `ACS_RST_VGA_GAIN;
            clkHalve_r <= 1'b0;
            outEnable_r <= 1'b0;
            syncCtrl_r <= `ACS_RST_SYNC_CTRL;
            coreRun_r <= 1'b0;
            oscEn_r <= 1'b0;
            vertRole_r <= `ACS_RST_VERT;
            masterSel_r <= 1'b0;
            vertPol_r <= `ACS_RST_VERT;
            sampleLoc_r <= `ACS_RST_SAMPLE_LOC;
            outPhase_r <= `ACS_RST_OUT_PHASE;
            startup_r <= `ACS_RST_STARTUP;
        end else if (wrStrobe) begin
            case (regAddr)
                `ACS_ADDR_FE_CTRL: feCtrl_r <= wrData[11:0];
                `ACS_ADDR_OUT_FMT: outFmt_r <= wrData[11:0];
                `ACS_ADDR_CLAMP_LEVEL: clampLevel_r <= wrData[9:0];
                `ACS_ADDR_CDS_GAIN: cdsGain_r <= wrData[11:0];
                `ACS_ADDR_VGA_GAIN: vgaGain_r <= wrData[9:0];
                `ACS_ADDR_CLK_HALVE: clkHalve_r <= wrData[0];
                `ACS_ADDR_OUT_EN: outEnable_r <= wrData[0];
                // software sync bit is a strobe and never stored
                `ACS_ADDR_SYNC_CTRL: syncCtrl_r <= wrData[15:0] &
                    ~(16'h0001 << `ACS_SYNC_SW);
                `ACS_ADDR_CORE_RUN: coreRun_r <= wrData[0];
                `ACS_ADDR_OSC_EN: oscEn_r <= wrData[0];
                `ACS_ADDR_VERT_ROLE: vertRole_r <= wrData;
                `ACS_ADDR_MASTER: masterSel_r <= wrData[0];
                `ACS_ADDR_VERT_POL: vertPol_r <= wrData;
                `ACS_ADDR_SAMPLE_LOC: sampleLoc_r <= wrData[11:0];
                `ACS_ADDR_OUT_PHASE: outPhase_r <= wrData[7:0];
                `ACS_ADDR_STARTUP: startup_r <= wrData[11:0];
                default: startup_r <= startup_r;
            endcase
        end
    end

    // pin synchronisers, sync pulse qualification and pixel/line/field counters
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pbSync_r <= 2'b11;
            clpSync_r <= 2'b00;
            synSync_r <= 2'b11;
            synLast_r <= 1'b1;
            lowCnt_r <= 2'h0;
            halfTick_r <= 1'b0;
            started_r <= 1'b0;
            outputsActive_r <= 1'b0;
            edgeCnt_r <= 6'h00;
            pixelCnt_r <= 8'h00;
            lineCnt_r <= 8'h00;
            xferLevel_r <= 1'b0;
        end else begin
            pbSync_r <= {pbSync_r[0], preblankN};
            clpSync_r <= {clpSync_r[0], blackClampPulse};
            synSync_r <= {synSync_r[0], syncN};
            synLast_r <= synSync_r[1];
            if (synSync_r[1]) begin
                lowCnt_r <= 2'h0;
            end else if (lowCnt_r != 2'h3) begin
                lowCnt_r <= lowCnt_r + 2'h1;
            end
            halfTick_r <= coreOn ? ~halfTick_r : 1'b0;
            if (softReset || !coreOn) begin
                started_r <= 1'b0;
                outputsActive_r <= 1'b0;
                edgeCnt_r <= 6'h00;
                pixelCnt_r <= 8'h00;
                lineCnt_r <= 8'h00;
                xferLevel_r <= 1'b0;
            end else if (syncEvent) begin
                // counters restart and pending enable applies at sync
                started_r <= 1'b1;
                outputsActive_r <= outEnable_r;
                edgeCnt_r <= 6'h00;
                pixelCnt_r <= 8'h00;
                lineCnt_r <= 8'h00;
                xferLevel_r <= 1'b0;
            end else if (tick && started_r) begin
                edgeCnt_r <= lastEdge ? 6'h00 : edgeCnt_r + 6'h01;
                if (lastEdge) begin
                    pixelCnt_r <= lastPixel ? 8'h00 : pixelCnt_r + 8'h01;
                    if (lastPixel) begin
                        lineCnt_r <= lastLine ? 8'h00 : lineCnt_r + 8'h01;
                        xferLevel_r <= ~xferLevel_r;
                    end
                end
                if (fieldStart) begin
                    outputsActive_r <= outEnable_r;
                end
            end
        end
    end

    // optical black clamp loop
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clpLast_r <= 1'b0;
            errAcc_r <= 16'h0000;
            clampLoop_r <= 10'h000;
            rateCnt_r <= 4'h0;
        end else if (softReset) begin
            clpLast_r <= 1'b0;
            errAcc_r <= 16'h0000;
            clampLoop_r <= 10'h000;
            rateCnt_r <= 4'h0;
        end else begin
            clpLast_r <= clpSync_r[1];
            if (clampOn && clpSync_r[1] && tick && started_r && dataEdge) begin
                // target counts quarter LSB steps
                errAcc_r <= (adcQuarter > {4'h0, clampLevel_r}) ?
                    errAcc_r + 16'h0001 : errAcc_r - 16'h0001;
            end else if (clpLast_r && !clpSync_r[1]) begin
                rateCnt_r <= clampDue ? 4'h0 : rateCnt_r + 4'h1;
                if (clampOn && clampDue) begin
                    errAcc_r <= 16'h0000;
                    if (!errAcc_r[15] && errAcc_r != 16'h0000 && clampLoop_r != 10'h000) begin
                        clampLoop_r <= clampLoop_r - 10'h001;
                    end else if (errAcc_r[15] && clampLoop_r != 10'h3FF) begin
                        clampLoop_r <= clampLoop_r + 10'h001;
                    end
                end
            end
        end
    end

    // registered outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dcRestoreSwitch <= 1'b0;
            samplerShort <= 1'b0;
            referenceSamplePulse <= 1'b0;
            dataSamplePulse <= 1'b0;
            cdsGainCode <= 2'b00;
            vgaGainCode <= 10'h000;
            clampCorrection <= 10'h000;
            powerMode <= 2'b00;
            oscillatorEnable <= 1'b0;
            dataOut <= 12'h000;
            dataOutOe <= 1'b0;
            outputDataClock <= 1'b0;
            verticalOut <= `ACS_RST_VERT;
            verticalDrive <= 1'b0;
            horizontalDrive <= 1'b0;
        end else begin
            referenceSamplePulse <= tick && started_r && refEdge;
            dataSamplePulse <= tick && started_r && dataEdge;
            dcRestoreSwitch <= tick && started_r && refEdge &&
                (!preblankActive || feCtrl_r[`ACS_FE_DC_IN_PREBLANK_PULSE]);
            samplerShort <= preblankActive;
            cdsGainCode <= cdsGain_r[1:0];
            vgaGainCode <= vgaGain_r;
            clampCorrection <= clampOn ? clampLoop_r : clampLevel_r;
            powerMode <= feCtrl_r[`ACS_FE_POWER];
            oscillatorEnable <= oscEn_r && !deepStandby;
            if (outFmt_r[`ACS_FMT_TRANSPARENT]) begin
                dataOut <= codedData;
            end else if (tick && started_r && edgeCnt_r == phasePos) begin
                dataOut <= codedData;
            end
            dataOutOe <= driveData;
            outputDataClock <= driveData && (outPhase_r[`ACS_PH_INV] ^
                (outPhase_r[`ACS_PH_FIXED] ? (edgeCnt_r < EDGES_PER_PIXEL / 2) :
                (phaseOffset < EDGES_PER_PIXEL / 2)));
            if (deepStandby) begin
                verticalOut <= vertPol_r;
            end else if (outputsActive_r) begin
                verticalOut <= (vertRole_r & {24{fieldStart}}) |
                    (~vertRole_r & {24{xferLevel_r}});
            end else begin
                verticalOut <= `ACS_RST_VERT;
            end
            verticalDrive <= outputsActive_r && started_r && lineCnt_r == 8'h00;
            horizontalDrive <= outputsActive_r && started_r && pixelCnt_r == 8'h00;
        end
    end
endmodule // acs_top

// >>> dv/acs_host_model.sv
`timescale 1ns/10ps
module acs_host_model (
    input wire clk,
    input wire serialDataOut,
    input wire serialDataOe,
    output reg serialClk,
    output reg serialDataIn,
    output reg serialLoadN
);
    initial begin
        serialClk = 1'b0;
        serialDataIn = 1'b0;
        serialLoadN = 1'b1;
    end
    // one frame: rw, address, data, msb first; clock idles low between frames
    task xfer(input rw, input [11:0] addr, input [23:0] wd, output [23:0] rd);
        reg [36:0] f;
        integer i;
        begin
            f = {rw, addr, wd};
            rd = 24'h0;
            @(negedge clk) serialLoadN = 1'b0;
            for (i = 36; i >= 0; i = i - 1) begin
                // on reads the data phase is ours to scramble
                serialDataIn = (rw && i < 24) ? ~serialDataIn : f[i];
                repeat (6) @(negedge clk);
                if (i < 24) rd[i] = serialDataOe & serialDataOut;
                serialClk = 1'b1;
                repeat (4) @(negedge clk);
                serialClk = 1'b0;
            end
            repeat (4) @(negedge clk);
            serialLoadN = 1'b1;
            repeat (8) @(negedge clk);
        end
    endtask
endmodule // acs_host_model

// >>> dv/acs_top_assertions.sv
`timescale 1ns/10ps
module acs_top_assertions (
    input wire clk,
    input wire rst,
    input wire preblankN,
    input wire dcRestoreSwitch,
    input wire samplerShort,
    input wire referenceSamplePulse,
    input wire dataSamplePulse,
    input wire [1:0] powerMode,
    input wire oscillatorEnable,
    input wire verticalDrive,
    input wire horizontalDrive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_blank_held;
        (!preblankN)[*5];
    endsequence
    sequence s_blank_free;
        preblankN[*5];
    endsequence
    a_dcr_ref_only: assert property (dcRestoreSwitch |-> referenceSamplePulse)
        else $error("dc restore outside reference sample");
    a_blank_shorts: assert property (s_blank_held |-> samplerShort)
        else $error("sampler not shorted in preblank");
    a_free_open: assert property (s_blank_free |-> !samplerShort)
        else $error("sampler shorted outside preblank");
    a_ref_one_shot: assert property (referenceSamplePulse |=> !referenceSamplePulse)
        else $error("reference pulse too long");
    a_data_one_shot: assert property (dataSamplePulse |=> !dataSamplePulse)
        else $error("data pulse too long");
    a_osc_deep_off: assert property ((powerMode == 2'h3) && ($past(powerMode) == 2'h3)
        |-> !oscillatorEnable)
        else $error("oscillator on in deepest standby");
    a_hd_pixel_hold: assert property ($rose(horizontalDrive) |=> horizontalDrive[*8])
        else $error("horizontal drive too short");
    a_vd_with_hd: assert property ($rose(verticalDrive) |-> $rose(horizontalDrive))
        else $error("vertical drive not at line start");
endmodule // acs_top_assertions
bind acs_top acs_top_assertions acs_top_assertions_inst (.clk(clk), .rst(rst),
    .preblankN(preblankN), .dcRestoreSwitch(dcRestoreSwitch), .samplerShort(samplerShort),
    .referenceSamplePulse(referenceSamplePulse), .dataSamplePulse(dataSamplePulse),
    .powerMode(powerMode), .oscillatorEnable(oscillatorEnable),
    .verticalDrive(verticalDrive), .horizontalDrive(horizontalDrive));

// >>> dv/acs_top_tb.sv
`timescale 1ns/10ps
module acs_top_tb;
    reg clk, rst, preblankN, blackClampPulse, syncN;
    reg [11:0] adcData;
    integer numErrors, nTests, cyc, i;
    wire serialClk, serialDataIn, serialLoadN, serialDataOut, serialDataOe;
    wire dcRestoreSwitch, samplerShort, referenceSamplePulse, dataSamplePulse;
    wire oscillatorEnable, dataOutOe, outputDataClock, verticalDrive, horizontalDrive;
    wire [1:0] cdsGainCode, powerMode;
    wire [9:0] vgaGainCode, clampCorrection;
    wire [11:0] dataOut;
    wire [23:0] verticalOut;
    acs_host_model acs_host_model_inst (.clk(clk), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .serialClk(serialClk), .serialDataIn(serialDataIn),
        .serialLoadN(serialLoadN));
    acs_top #(.EDGES_PER_PIXEL(64), .PIXELS_PER_LINE(4), .LINES_PER_FIELD(4)) acs_top_inst (
        .clk(clk), .rst(rst), .serialClk(serialClk), .serialDataIn(serialDataIn),
        .serialLoadN(serialLoadN), .preblankN(preblankN), .blackClampPulse(blackClampPulse),
        .syncN(syncN), .adcData(adcData), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .dcRestoreSwitch(dcRestoreSwitch),
        .samplerShort(samplerShort), .referenceSamplePulse(referenceSamplePulse),
        .dataSamplePulse(dataSamplePulse), .cdsGainCode(cdsGainCode),
        .vgaGainCode(vgaGainCode), .clampCorrection(clampCorrection), .powerMode(powerMode),
        .oscillatorEnable(oscillatorEnable), .dataOut(dataOut), .dataOutOe(dataOutOe),
        .outputDataClock(outputDataClock), .verticalOut(verticalOut),
        .verticalDrive(verticalDrive), .horizontalDrive(horizontalDrive));
    task chk(input [23:0] seen, input [23:0] exp);
        begin
            nTests = nTests + 1;
            if (seen !== exp) begin
                numErrors = numErrors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [11:0] a, input [23:0] d);
        reg [23:0] x;
        begin
            acs_host_model_inst.xfer(1'b0, a, d, x);
        end
    endtask
    task rdc(input [11:0] a, input [23:0] e);
        reg [23:0] x;
        begin
            acs_host_model_inst.xfer(1'b1, a, 24'h0, x);
            chk(x, e);
        end
    endtask
    task tallyAndFinish;
        begin
            $display("comparisons %0d mismatches %0d", nTests, numErrors);
            if (numErrors == 0 && nTests > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        cyc = 0;
        forever @(posedge clk) begin
            cyc = cyc + 1;
            if (cyc == 40000) begin
                numErrors = numErrors + 1;
                tallyAndFinish;
            end
        end
    end
    initial begin
        rst = 1'b1;
        preblankN = 1'b1;
        blackClampPulse = 1'b0;
        syncN = 1'b1;
        adcData = 12'hA5C;
        numErrors = 0;
        nTests = 0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(24'(powerMode), 24'h3);
        chk(verticalOut, 24'h0);
        rdc(12'h000, 24'h3);
        rdc(12'h037, 24'h800);
        rdc(12'h014, 24'h0);
        rdc(12'h0FF, 24'h0);
        wr(12'h004, 24'h2);
        chk(24'(cdsGainCode), 24'h2);
        wr(12'h005, 24'h3FF);
        chk(24'(vgaGainCode), 24'h3FF);
        wr(12'h003, 24'h155);
        wr(12'h000, 24'h0);
        chk(24'(clampCorrection), 24'h155);
        chk(24'(powerMode), 24'h0);
        wr(12'h013, 24'h4001);
        rdc(12'h013, 24'h1);
        wr(12'h010, 24'h1);
        chk(24'(cdsGainCode), 24'h0);
        rdc(12'h000, 24'h3);
        wr(12'h004, 24'h1);
        chk(24'(cdsGainCode), 24'h1);
        // start-up order, hardware sync last
        wr(12'h0D8, 24'h888);
        rdc(12'h0D8, 24'h888);
        wr(12'h000, 24'h4);
        wr(12'h015, 24'h1);
        chk(24'(oscillatorEnable), 24'h1);
        wr(12'h014, 24'h1);
        wr(12'h020, 24'h1);
        wr(12'h011, 24'h1);
        chk(24'(dataOutOe), 24'h0);
        syncN = 1'b0;
        repeat (3) @(negedge clk);
        syncN = 1'b1;
        for (i = 0; i < 3000 && dataOutOe !== 1'b1; i = i + 1) @(negedge clk);
        chk(24'(dataOutOe), 24'h1);
        preblankN = 1'b0;
        repeat (10) @(negedge clk);
        chk(24'(samplerShort), 24'h1);
        preblankN = 1'b1;
        repeat (10) @(negedge clk);
        chk(24'(samplerShort), 24'h0);
        wr(12'h001, 24'h6);
        chk(24'(dataOut), 24'(adcData ^ (adcData >> 1)));
        wr(12'h001, 24'h2);
        chk(24'(dataOut), 24'(adcData));
        wr(12'h001, 24'h1);
        chk(24'(dataOutOe), 24'h0);
        wr(12'h001, 24'h0);
        chk(24'(dataOutOe), 24'h1);
        wr(12'h038, 24'h8);
        @(posedge referenceSamplePulse) @(negedge clk);
        chk(24'(outputDataClock), 24'h0);
        adcData = 12'h3C3;
        repeat (70) @(negedge clk);
        chk(24'(dataOut), 24'h3C3);
        wr(12'h038, 24'h48);
        @(posedge referenceSamplePulse) @(negedge clk);
        chk(24'(outputDataClock), 24'h1);
        wr(12'h038, 24'hC8);
        @(posedge referenceSamplePulse) @(negedge clk);
        chk(24'(outputDataClock), 24'h0);
        wr(12'h003, 24'h10);
        adcData = 12'h000;
        blackClampPulse = 1'b1;
        repeat (1300) @(negedge clk);
        blackClampPulse = 1'b0;
        wr(12'h011, 24'h0);
        chk(24'(clampCorrection), 24'h1);
        repeat (1100) @(negedge clk);
        chk(24'(dataOutOe), 24'h0);
        wr(12'h014, 24'h0);
        syncN = 1'b0;
        wr(12'h011, 24'h1);
        wr(12'h014, 24'h1);
        wr(12'h013, 24'h4001);
        chk(24'(dataOutOe), 24'h1);
        tallyAndFinish;
    end
endmodule // acs_top_tb
